//--- verilog/sed_dispatch.sv
// system entry dispatcher: argument setup, frame push, error progress flags
//
// Operation
// - interrupt entry puts type code in a0
// - interrupt entry sets level per source
// - level raised first; a1 holds vector
// - error entries: vector a1, logout address a2
// - machine check busy set before entry
// - machine check while busy halts
// - correctable error sets matching busy flag
// - logout area untouched while report outstanding
// - mute flags: correct, but no interrupt
// - only flag bits 4..0 are architected
// - memory fault: va, status, cause code
// - system call touches only stack frame
// - unaligned: va, opcode, register field
// - faulting stack access halts
// - misaligned stack pointer halts
// - frame holds status, pc, gp, a0..a2 (system call: status, pc, gp only)
// - status mode bit and level bits
`timescale 1ns/1ps
module sed_dispatch #(
    parameter logic [sed_pkg::XLEN-1:0] LOGOUT_RESET = 64'h0,
    parameter logic [sed_pkg::XLEN-1:0] KSP_RESET = 64'h0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire sed_pkg::sed_req_type req,
    input wire logic stack_fault,
    input wire logic [sed_pkg::REG_AW-1:0] reg_addr,
    input wire logic [sed_pkg::XLEN-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sed_pkg::XLEN-1:0] reg_rdata,
    output sed_pkg::sed_stack_wr_type stack_wr,
    output logic taken,
    output sed_pkg::sed_src_type taken_src,
    output logic corr_done,
    output logic entry_valid,
    output sed_pkg::sed_entry_type entry_kind,
    output logic [sed_pkg::XLEN-1:0] arg_a0,
    output logic [sed_pkg::XLEN-1:0] arg_a1,
    output logic [sed_pkg::XLEN-1:0] arg_a2,
    output logic [sed_pkg::PS_W-1:0] processor_status,
    output logic logout_write_ok,
    output logic halt_double_check,
    output logic halt_stack_invalid
);
    import sed_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_PUSH, ST_ENTER, ST_HALT
    } sed_state_type;

    // ************************************************
    // state
    // ************************************************
    sed_state_type state;
    logic [FLAG_W-1:0] error_progress_flags;
    logic [FLAG_W-1:0] next_flags;
    logic [XLEN-1:0] kernel_sp;
    logic [XLEN-1:0] logout_base;
    logic [XLEN-1:0] frame_sp;
    logic [XLEN-1:0] save_pc;
    logic [XLEN-1:0] save_gp;
    logic [PS_W-1:0] save_ps;
    logic [XLEN-1:0] hold_a0;
    logic [XLEN-1:0] hold_a1;
    logic [XLEN-1:0] hold_a2;
    logic [IPL_W-1:0] hold_ipl;
    logic hold_raise;
    sed_entry_type hold_kind;
    logic [IDX_W-1:0] push_idx;
    logic [IDX_W-1:0] push_last;

    // ************************************************
    // source selection
    // ************************************************
    sed_src_type pick;
    logic silent_sce;
    logic silent_pce;
    logic double_mc;
    logic [IPL_W-1:0] cur_ipl;
    logic [IPL_W-1:0] pick_ipl;
    logic [XLEN-1:0] pick_a0;
    logic [XLEN-1:0] pick_a1;
    logic [XLEN-1:0] pick_a2;
    sed_entry_type pick_kind;

    assign cur_ipl = processor_status[IPL_W-1:0];

    always_comb begin
        silent_sce = req.sys_ce && (error_progress_flags[SMUTE_BIT]
            || error_progress_flags[SCE_BIT]);
        silent_pce = req.proc_ce && (error_progress_flags[PMUTE_BIT]
            || error_progress_flags[PCE_BIT]);
        double_mc = req.mchk && error_progress_flags[MC_BIT];
        pick = SRC_NONE;
        if (req.mchk && !double_mc && IPL_ERR > cur_ipl) begin
            pick = SRC_MCHK;
        end else if (req.mm) begin
            pick = SRC_MM;
        end else if (req.una) begin
            pick = SRC_UNA;
        end else if (req.sys) begin
            pick = SRC_SYS;
        end else if (req.sys_ce && !silent_sce && IPL_ERR > cur_ipl) begin
            pick = SRC_SCE;
        end else if (req.proc_ce && !silent_pce && IPL_ERR > cur_ipl) begin
            pick = SRC_PCE;
        end else if (req.perf && IPL_PERF > cur_ipl) begin
            pick = SRC_PERF;
        end else if (req.clk && IPL_CLK > cur_ipl) begin
            pick = SRC_CLK;
        end else if (req.ipi && IPL_IPI > cur_ipl) begin
            pick = SRC_IPI;
        end else if (req.io && req.io_ipl > cur_ipl) begin
            pick = SRC_IO;
        end
    end

    // argument values and level for the chosen source
    always_comb begin
        pick_a0 = hold_a0;
        pick_a1 = hold_a1;
        pick_a2 = hold_a2;
        pick_ipl = cur_ipl;
        pick_kind = ENT_INT;
        unique case (pick)
            SRC_MCHK, SRC_SCE, SRC_PCE: begin
                pick_a0 = XLEN'(TYPE_ERR);
                pick_a1 = req.vector;
                pick_a2 = logout_base;
                pick_ipl = IPL_ERR;
            end
            SRC_PERF: begin
                pick_a0 = XLEN'(TYPE_PERF);
                pick_a1 = req.vector;
                pick_ipl = IPL_PERF;
            end
            SRC_CLK: begin
                pick_a0 = XLEN'(TYPE_CLK);
                pick_a1 = req.vector;
                pick_ipl = IPL_CLK;
            end
            SRC_IPI: begin
                pick_a0 = XLEN'(TYPE_IPI);
                pick_a1 = req.vector;
                pick_ipl = IPL_IPI;
            end
            SRC_IO: begin
                pick_a0 = XLEN'(TYPE_IO);
                pick_a1 = req.vector;
                pick_ipl = req.io_ipl;
            end
            SRC_MM: begin
                pick_kind = ENT_MM;
                pick_a0 = req.va;
                pick_a1 = req.mm_status;
                if (req.mm_access == ACC_FETCH) begin
                    pick_a2 = CAUSE_FETCH;
                end else if (req.mm_access == ACC_STORE) begin
                    pick_a2 = CAUSE_STORE;
                end else begin
                    pick_a2 = CAUSE_LOAD;
                end
            end
            SRC_UNA: begin
                pick_kind = ENT_UNA;
                pick_a0 = req.va;
                pick_a1 = XLEN'(req.insn[OPC_LSB +: OPC_W]);
                pick_a2 = XLEN'(req.insn[RFLD_LSB +: RFLD_W]);
            end
            SRC_SYS: begin
                pick_kind = ENT_SYS;
            end
            SRC_NONE: begin
                pick_kind = ENT_NONE;
            end
        endcase
    end

    // ************************************************
    // entry sequencer
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            push_idx <= '0;
            push_last <= '0;
            frame_sp <= '0;
            save_pc <= '0;
            save_gp <= '0;
            save_ps <= '0;
            hold_a0 <= '0;
            hold_a1 <= '0;
            hold_a2 <= '0;
            hold_ipl <= '0;
            hold_raise <= 1'b0;
            hold_kind <= ENT_NONE;
            taken <= 1'b0;
            taken_src <= SRC_NONE;
            corr_done <= 1'b0;
            halt_double_check <= 1'b0;
            halt_stack_invalid <= 1'b0;
        end else begin
            taken <= 1'b0;
            corr_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (double_mc) begin
                        halt_double_check <= 1'b1;
                        state <= ST_HALT;
                    end else if (pick != SRC_NONE) begin
                        taken <= 1'b1;
                        taken_src <= pick;
                        hold_kind <= pick_kind;
                        hold_ipl <= pick_ipl;
                        hold_raise <= (pick_kind == ENT_INT);
                        hold_a0 <= pick_a0;
                        hold_a1 <= pick_a1;
                        hold_a2 <= pick_a2;
                        save_ps <= processor_status;
                        save_gp <= req.gp;
                        save_pc <= (pick == SRC_SYS) ?
                            req.pc + PC_STEP : req.pc;
                        frame_sp <= kernel_sp - FRAME_BYTES;
                        push_last <= (pick == SRC_SYS) ?
                            SYS_WORDS - 3'h1 : FRAME_WORDS - 3'h1;
                        push_idx <= '0;
                        state <= ST_CHECK;
                    end else if (silent_sce || silent_pce) begin
                        corr_done <= 1'b1;
                        taken <= 1'b1;
                        taken_src <= silent_sce ? SRC_SCE : SRC_PCE;
                    end
                end
                ST_CHECK: begin
                    if ((kernel_sp[2:0] & QW_MASK) != 3'h0) begin
                        halt_stack_invalid <= 1'b1;
                        state <= ST_HALT;
                    end else begin
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (stack_fault) begin
                        halt_stack_invalid <= 1'b1;
                        state <= ST_HALT;
                    end else if (push_idx == push_last) begin
                        state <= ST_ENTER;
                    end else begin
                        push_idx <= push_idx + 3'h1;
                    end
                end
                ST_ENTER: begin
                    state <= ST_IDLE;
                end
                ST_HALT: begin
                    state <= ST_HALT;
                end
            endcase
        end
    end

    // stack frame writes, one quadword a cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stack_wr <= '0;
        end else begin
            stack_wr.valid <= 1'b0;
            if ((state == ST_CHECK && (kernel_sp[2:0] & QW_MASK) == 3'h0)
                || (state == ST_PUSH && !stack_fault
                && push_idx != push_last)) begin
                stack_wr.valid <= 1'b1;
            end
            stack_wr.addr <= frame_sp
                + (XLEN'(next_push_idx()) << QW_SHIFT);
            unique case (next_push_idx())
                3'h0: stack_wr.data <= XLEN'(save_ps);
                3'h1: stack_wr.data <= save_pc;
                3'h2: stack_wr.data <= save_gp;
                3'h3: stack_wr.data <= hold_a0;
                3'h4: stack_wr.data <= hold_a1;
                default: stack_wr.data <= hold_a2;
            endcase
        end
    end

    function automatic logic [IDX_W-1:0] next_push_idx();
        return (state == ST_PUSH) ? push_idx + 3'h1 : 3'h0;
    endfunction

    // handler invocation
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            entry_valid <= 1'b0;
            entry_kind <= ENT_NONE;
            arg_a0 <= '0;
            arg_a1 <= '0;
            arg_a2 <= '0;
        end else begin
            entry_valid <= 1'b0;
            if (state == ST_ENTER) begin
                entry_valid <= 1'b1;
                entry_kind <= hold_kind;
                if (hold_kind != ENT_SYS) begin
                    arg_a0 <= hold_a0;
                    arg_a1 <= hold_a1;
                    arg_a2 <= hold_a2;
                end
            end
        end
    end

    // ************************************************
    // processor status and stack pointer
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            processor_status <= PS_RESET;
        end else if (state == ST_CHECK) begin
            processor_status[PS_MODE_BIT] <= 1'b0;
            if (hold_raise) begin
                processor_status[IPL_W-1:0] <= hold_ipl;
            end
        end else if (reg_wr && reg_addr == REG_PS) begin
            processor_status[PS_MODE_BIT] <= reg_wdata[PS_MODE_BIT];
            processor_status[IPL_W-1:0] <= reg_wdata[PS_MODE_BIT] ?
                IPL_ZERO : reg_wdata[IPL_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            kernel_sp <= KSP_RESET;
            logout_base <= LOGOUT_RESET;
        end else begin
            if (state == ST_ENTER) begin
                kernel_sp <= frame_sp;
            end else if (reg_wr && reg_addr == REG_KSP) begin
                kernel_sp <= reg_wdata;
            end
            if (reg_wr && reg_addr == REG_LOGOUT) begin
                logout_base <= reg_wdata;
            end
        end
    end

    // ************************************************
    // error progress flags
    // ************************************************
    always_comb begin
        next_flags = error_progress_flags;
        if (reg_wr && reg_addr == REG_FLAGS) begin
            next_flags[PMUTE_BIT] = reg_wdata[PMUTE_BIT];
            next_flags[SMUTE_BIT] = reg_wdata[SMUTE_BIT];
            next_flags = next_flags
                & ~(reg_wdata[FLAG_W-1:0] & BUSY_MASK);
        end
        if (state == ST_IDLE && pick == SRC_MCHK) begin
            next_flags[MC_BIT] = 1'b1;
        end
        if (state == ST_IDLE && pick == SRC_SCE) begin
            next_flags[SCE_BIT] = 1'b1;
        end
        if (state == ST_IDLE && pick == SRC_PCE) begin
            next_flags[PCE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            error_progress_flags <= FLAGS_RESET;
            logout_write_ok <= 1'b1;
        end else begin
            error_progress_flags <= next_flags;
            logout_write_ok <= ~|(next_flags & BUSY_MASK);
        end
    end

    // ************************************************
    // register read port
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_FLAGS:
                    reg_rdata <= XLEN'(error_progress_flags);
                REG_KSP: reg_rdata <= kernel_sp;
                REG_LOGOUT: reg_rdata <= logout_base;
                REG_PS: reg_rdata <= XLEN'(processor_status);
                REG_STATE: reg_rdata <= XLEN'({halt_stack_invalid,
                    halt_double_check, state});
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

//--- verilog/sed_pkg.sv
// constants, types and register map of the system entry dispatcher
package sed_pkg;
    // ************************************************
    // widths
    // ************************************************
    localparam int XLEN = 64;
    localparam int REG_AW = 8;
    localparam int IPL_W = 3;
    localparam int FLAG_W = 5;
    localparam int IDX_W = 3;
    localparam int QW_SHIFT = 3;
    // ************************************************
    // register offsets (byte addresses)
    // ************************************************
    localparam logic [REG_AW-1:0] REG_FLAGS = 8'h00;
    localparam logic [REG_AW-1:0] REG_KSP = 8'h08;
    localparam logic [REG_AW-1:0] REG_LOGOUT = 8'h10;
    localparam logic [REG_AW-1:0] REG_PS = 8'h18;
    localparam logic [REG_AW-1:0] REG_STATE = 8'h20;
    // ************************************************
    // error_progress_flags fields
    // ************************************************
    localparam int MC_BIT = 0;
    localparam int SCE_BIT = 1;
    localparam int PCE_BIT = 2;
    localparam int PMUTE_BIT = 3;
    localparam int SMUTE_BIT = 4;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
    localparam logic [FLAG_W-1:0] BUSY_MASK = 5'h07;
    // ************************************************
    // processor_status fields
    // ************************************************
    localparam int PS_W = 4;
    localparam int PS_MODE_BIT = 3;
    localparam logic [PS_W-1:0] PS_RESET = 4'h7;
    localparam logic [IPL_W-1:0] IPL_ZERO = 3'h0;
    // ************************************************
    // interrupt type codes and levels
    // ************************************************
    localparam logic [2:0] TYPE_IPI = 3'h0;
    localparam logic [2:0] TYPE_CLK = 3'h1;
    localparam logic [2:0] TYPE_ERR = 3'h2;
    localparam logic [2:0] TYPE_IO = 3'h3;
    localparam logic [2:0] TYPE_PERF = 3'h4;
    localparam logic [IPL_W-1:0] IPL_IPI = 3'h5;
    localparam logic [IPL_W-1:0] IPL_CLK = 3'h5;
    localparam logic [IPL_W-1:0] IPL_ERR = 3'h7;
    localparam logic [IPL_W-1:0] IPL_PERF = 3'h6;
    // ************************************************
    // memory fault causes and access kinds
    // ************************************************
    localparam logic [XLEN-1:0] CAUSE_FETCH = 64'hffff_ffff_ffff_ffff;
    localparam logic [XLEN-1:0] CAUSE_STORE = 64'h0000_0000_0000_0001;
    localparam logic [XLEN-1:0] CAUSE_LOAD = 64'h0000_0000_0000_0000;
    localparam logic [1:0] ACC_FETCH = 2'h0;
    localparam logic [1:0] ACC_STORE = 2'h1;
    localparam logic [1:0] ACC_LOAD = 2'h2;
    // ************************************************
    // instruction fields and stack frame
    // ************************************************
    localparam int OPC_LSB = 26;
    localparam int OPC_W = 6;
    localparam int RFLD_LSB = 21;
    localparam int RFLD_W = 5;
    localparam logic [XLEN-1:0] PC_STEP = 64'h4;
    localparam logic [XLEN-1:0] FRAME_BYTES = 64'h30;
    localparam logic [IDX_W-1:0] FRAME_WORDS = 3'h6;
    localparam logic [IDX_W-1:0] SYS_WORDS = 3'h3;
    localparam logic [2:0] QW_MASK = 3'h7;
    // ************************************************
    // types
    // ************************************************
    typedef enum logic [2:0] {
        ENT_NONE, ENT_INT, ENT_MM, ENT_SYS, ENT_UNA
    } sed_entry_type;
    typedef enum logic [3:0] {
        SRC_NONE, SRC_MCHK, SRC_MM, SRC_UNA, SRC_SYS, SRC_SCE,
        SRC_PCE, SRC_PERF, SRC_CLK, SRC_IPI, SRC_IO
    } sed_src_type;
    typedef struct packed {
        logic ipi;
        logic clk;
        logic io;
        logic perf;
        logic mchk;
        logic sys_ce;
        logic proc_ce;
        logic mm;
        logic una;
        logic sys;
        logic [IPL_W-1:0] io_ipl;
        logic [XLEN-1:0] vector;
        logic [XLEN-1:0] va;
        logic [XLEN-1:0] mm_status;
        logic [1:0] mm_access;
        logic [31:0] insn;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] gp;
    } sed_req_type;
    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] addr;
        logic [XLEN-1:0] data;
    } sed_stack_wr_type;
endpackage

//--- dv/sed_dispatch_assertions.sv
// assertion checker for the system entry dispatcher
`timescale 1ns/1ps
module sed_dispatch_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stack_fault,
    input wire sed_pkg::sed_stack_wr_type stack_wr,
    input wire logic taken,
    input wire sed_pkg::sed_src_type taken_src,
    input wire logic entry_valid,
    input wire logic [sed_pkg::XLEN-1:0] arg_a0,
    input wire logic [sed_pkg::XLEN-1:0] arg_a2,
    input wire logic [sed_pkg::PS_W-1:0] processor_status,
    input wire logic logout_write_ok,
    input wire logic halt_double_check,
    input wire logic halt_stack_invalid
);
    import sed_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ****************
    // entry checks
    // ****************
    property p_clk_ipl;
        taken && taken_src == SRC_CLK |=> processor_status == {1'b0, IPL_CLK};
    endproperty
    a_clk_ipl: assert property (p_clk_ipl)
        else $error("clock level");
    property p_err_ipl;
        taken && taken_src == SRC_MCHK |=> processor_status[2:0] == IPL_ERR;
    endproperty
    a_err_ipl: assert property (p_err_ipl)
        else $error("check level");
    property p_clk_a0;
        taken && taken_src == SRC_CLK ##8 !halt_stack_invalid
            |-> entry_valid && arg_a0 == 64'h1;
    endproperty
    a_clk_a0: assert property (p_clk_a0) else $error("clock type");
    property p_mc_busy;
        taken && taken_src == SRC_MCHK |-> ##[0:2] !logout_write_ok;
    endproperty
    a_mc_busy: assert property (p_mc_busy)
        else $error("logout open");
    property p_dbl;
        halt_double_check |=> halt_double_check && !entry_valid;
    endproperty
    a_dbl: assert property (p_dbl) else $error("double halt");
    property p_stk_fault;
        stack_wr.valid && stack_fault |=> halt_stack_invalid;
    endproperty
    a_stk_fault: assert property (p_stk_fault)
        else $error("no halt");
    property p_stk_align;
        stack_wr.valid |-> stack_wr.addr[2:0] == 3'h0;
    endproperty
    a_stk_align: assert property (p_stk_align)
        else $error("misaligned");
    property p_sys_args;
        taken && taken_src == SRC_SYS ##5 !halt_stack_invalid
            |-> entry_valid && $stable(arg_a0) && $stable(arg_a2);
    endproperty
    a_sys_args: assert property (p_sys_args)
        else $error("sys args");
    property p_user_ipl;
        processor_status[3] |-> processor_status[2:0] == IPL_ZERO;
    endproperty
    a_user_ipl: assert property (p_user_ipl)
        else $error("user level");
endmodule
bind sed_dispatch sed_dispatch_checker u_chk (
    .core_clk, .nrst, .stack_fault, .stack_wr, .taken, .taken_src,
    .entry_valid, .arg_a0, .arg_a2, .processor_status,
    .logout_write_ok, .halt_double_check, .halt_stack_invalid
);

//--- dv/sed_dispatch_tb_top.sv
// self-checking bench for the system entry dispatcher
`timescale 1ns/1ps
module sed_dispatch_tb_top;
    import sed_pkg::*;
    logic core_clk, nrst, stack_fault, reg_wr, reg_rd, rd_q, seen;
    logic taken, corr_done, entry_valid, logout_write_ok;
    logic halt_double_check, halt_stack_invalid;
    sed_req_type req;
    logic [REG_AW-1:0] reg_addr;
    logic [XLEN-1:0] reg_wdata, reg_rdata, arg_a0, arg_a1, arg_a2, v, va, lo;
    logic [PS_W-1:0] processor_status;
    logic [31:0] ins;
    sed_stack_wr_type stack_wr;
    sed_src_type taken_src;
    sed_entry_type entry_kind;
    logic [194:0] eq[$], mq[$];
    logic [XLEN-1:0] rq[$], swd[$];
    logic [9:0] im[4] = '{10'h200, 10'h100, 10'h080, 10'h040};
    logic [2:0] it[4] = '{TYPE_IPI, TYPE_CLK, TYPE_IO, TYPE_PERF};
    logic [2:0] lv[4] = '{IPL_IPI, IPL_CLK, 3'h3, IPL_PERF};
    logic [XLEN-1:0] cz[3] = '{CAUSE_FETCH, CAUSE_STORE, CAUSE_LOAD};
    int n_fail, compares, n_cd;
    sed_dispatch uut (.core_clk, .nrst, .req, .stack_fault, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stack_wr, .taken,
        .taken_src, .corr_done, .entry_valid, .entry_kind, .arg_a0,
        .arg_a1, .arg_a2, .processor_status, .logout_write_ok,
        .halt_double_check, .halt_stack_invalid);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ****************
    // tasks
    // ****************
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [194:0] g, e, m);
        compares++;
        if (((g ^ e) & m) !== '0) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task close_out;
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [63:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task rd(input logic [7:0] a, input logic [63:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        cyc(1);
        reg_rd <= 1'b0;
        cyc(2);
    endtask
    task note(input logic [2:0] k, input logic [63:0] x0, x1, x2,
              input logic [194:0] m);
        eq.push_back({k, x0, x1, x2});
        mq.push_back(m);
    endtask
    task go(input logic [9:0] m, input logic exp_seen);
        swd.delete();
        seen = 1'b0;
        req[$bits(req)-1 -: 10] <= m;
        repeat (20) if (!seen) begin
            cyc(1);
            seen = taken === 1'b1 || corr_done === 1'b1
                || halt_double_check === 1'b1;
        end
        req[$bits(req)-1 -: 10] <= '0;
        cyc(12);
        chk(seen, exp_seen, '1);
    endtask
    task rst(input logic [63:0] ksp);
        nrst <= 1'b0;
        cyc(8);
        nrst <= 1'b1;
        cyc(1);
        rd(REG_PS, 64'h7);
        rd(REG_FLAGS, 64'h0);
        wr(REG_KSP, ksp);
        wr(REG_LOGOUT, lo);
        wr(REG_PS, 64'h0);
    endtask
    // ****************
    // monitor
    // ****************
    always @(posedge core_clk) begin
        rd_q <= reg_rd;
        if (rd_q === 1'b1)
            chk(reg_rdata, rq.pop_front(), '1);
        if (entry_valid === 1'b1)
            chk({entry_kind, arg_a0, arg_a1, arg_a2}, eq.pop_front(),
                (mq.size() > 0) ? mq.pop_front() : '1);
        if (stack_wr.valid === 1'b1)
            swd.push_back(stack_wr.data);
        if (corr_done === 1'b1)
            n_cd++;
    end
    initial begin
        cyc(5000);
        n_fail++;
        close_out;
    end
    // ****************
    // sequence
    // ****************
    initial begin
        nrst = 1'b0;
        req = '0;
        stack_fault = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        n_fail = 0;
        compares = 0;
        void'($urandom(32'hc69d1f13));
        lo = {$urandom, $urandom} & ~64'h7;
        rst(64'h1000);
        wr(REG_PS, 64'hf);
        rd(REG_PS, 64'h8);
        rd(8'h38, 64'h0);
        for (int i = 0; i < 4; i++) begin
            v = {$urandom, $urandom};
            req.vector <= v;
            req.io_ipl <= 3'h3;
            note(ENT_INT, it[i], v, 0,
                {3'h7, {64{1'b1}}, {64{i > 1}}, 64'h0});
            go(im[i], 1'b1);
            chk(processor_status, {1'b0, lv[i]}, '1);
            chk(swd.size(), 6, '1);
            wr(REG_PS, 64'h0);
        end
        wr(REG_PS, 64'h5);
        go(10'h100, 1'b0);
        wr(REG_PS, 64'h0);
        note(ENT_INT, TYPE_ERR, v, lo, {3'h7, {64{1'b1}}, {128{1'b1}}});
        go(10'h010, 1'b1);
        wr(REG_PS, 64'h0);
        note(ENT_INT, TYPE_ERR, v, lo, '1);
        go(10'h008, 1'b1);
        wr(REG_PS, 64'h0);
        rd(REG_FLAGS, 64'h6);
        chk(logout_write_ok, 1'b0, '1);
        chk(n_cd, 0, '1);
        wr(REG_FLAGS, 64'hffff_ffff_ffff_ffff);
        go(10'h010, 1'b1);
        chk(n_cd != 0, 1'b1, '1);
        rd(REG_FLAGS, 64'h18);
        chk(logout_write_ok, 1'b1, '1);
        for (int i = 0; i < 3; i++) begin
            va = {$urandom, $urandom};
            v = {$urandom, $urandom};
            req.va <= va;
            req.mm_status <= v;
            req.mm_access <= 2'(i);
            note(ENT_MM, va, v, cz[i], '1);
            go(10'h004, 1'b1);
        end
        ins = $urandom;
        req.insn <= ins;
        note(ENT_UNA, va, ins[31:26], ins[25:21], '1);
        go(10'h002, 1'b1);
        v = {$urandom, $urandom};
        req.pc <= v;
        note(ENT_SYS, va, ins[31:26], ins[25:21], '1);
        go(10'h001, 1'b1);
        chk(swd.size(), 3, '1);
        chk(swd[1], v + PC_STEP, '1);
        note(ENT_INT, TYPE_ERR, v, lo, '1);
        req.vector <= v;
        go(10'h020, 1'b1);
        rd(REG_FLAGS, 64'h19);
        wr(REG_PS, 64'h0);
        go(10'h020, 1'b1);
        chk(halt_double_check, 1'b1, '1);
        wr(REG_FLAGS, 64'h19);
        rd(REG_FLAGS, 64'h18);
        rst(64'h1004);
        go(10'h001, 1'b1);
        chk(halt_stack_invalid, 1'b1, '1);
        chk(swd.size(), 0, '1);
        rst(64'h1000);
        stack_fault <= 1'b1;
        go(10'h100, 1'b1);
        chk(halt_stack_invalid, 1'b1, '1);
        chk(eq.size(), 0, '1);
        close_out;
    end
endmodule
